/* verilog/demod_cfg_pkg.sv */
// Constants, field layouts and channel and settings types for the demodulator and
// framing configuration register bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package demod_cfg_pkg;

   // Printed offsets are not multiples of four: they are word indices
   localparam logic [7:0] IDX_DEMOD = 8'h19;
   localparam logic [7:0] IDX_RSVD_A = 8'h1A;
   localparam logic [7:0] IDX_RSVD_B = 8'h1B;
   localparam logic [7:0] IDX_TX_TIMING = 8'h1C;
   localparam logic [7:0] IDX_RX_FRAMING = 8'h1D;
   localparam logic [7:0] IDX_RSVD_C = 8'h1E;
   localparam logic [7:0] IDX_UART_SPEED = 8'h1F;
   // Block-local register holding the timer divider value
   localparam logic [7:0] IDX_TIMER_DIV = 8'h30;
   // Read-only register showing the resolved channel and tick state
   localparam logic [7:0] IDX_STATUS = 8'h31;

   // Reset values
   localparam logic [7:0] RST_DEMOD = 8'h4D;
   localparam logic [7:0] RST_RSVD = 8'h00;
   localparam logic [7:0] RST_TX_TIMING = 8'h62;
   localparam logic [7:0] RST_RX_FRAMING = 8'h00;
   localparam logic [7:0] RST_UART_SPEED = 8'hEB;
   localparam logic [11:0] RST_TIMER_DIV = 12'h000;

   // Writable bit masks; other bits keep their reset value
   localparam logic [7:0] WMASK_DEMOD = 8'hFF;
   localparam logic [7:0] WMASK_TX_TIMING = 8'h03;
   localparam logic [7:0] WMASK_RX_FRAMING = 8'h10;
   localparam logic [7:0] WMASK_UART_SPEED = 8'hFF;

   // Field positions
   localparam int POS_COMBINE = 6;
   localparam int POS_LOCK = 5;
   localparam int POS_EVEN = 4;
   localparam int POS_TAU_RCV = 2;
   localparam int POS_TAU_BURST = 0;
   localparam int POS_PARITY_BYPASS = 4;
   localparam int POS_COARSE = 5;
   localparam int POS_FINE = 0;

   // Fixed bit periods added to the extra response time
   localparam logic [3:0] RESPONSE_BASE_BITS = 4'h7;

   // Channel choice codes
   typedef enum logic [1:0] {
      CH_STRONGER = 2'h0,
      CH_STRONGER_FROZEN = 2'h1,
      CH_FIXED_I = 2'h2,
      CH_FIXED_Q = 2'h3
   } channel_mode_e;

   // Settings handed to the receiver, PLL, framer and UART
   typedef struct packed {
      channel_mode_e channelMode;
      logic channelReserved;
      logic [1:0] pllTauReception;
      logic pllFreezeReception;
      logic [1:0] pllTauBurst;
      logic [3:0] responseBits;
      logic parityBypass;
      logic [2:0] baudCoarseFactor;
      logic [4:0] baudFineFactor;
   } cfg_out_s;

   // Timer tick divider bounds
   localparam int TIMER_DIV_WIDTH = 12;

endpackage : demod_cfg_pkg

/* verilog/timer_tick_gen.sv */
// Timer tick generator: divides the carrier-rate enable by
// 2*div+1 or 2*div+2.
// Assumes a carrier-rate enable from the same clock domain.
`timescale 1ns/1ps
module timer_tick_gen #(
   parameter int DIV_WIDTH = 12
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic carrierEn,
   input wire logic evenDivisor,
   input wire logic [DIV_WIDTH-1:0] divValue,
   output logic tick
);

   logic [DIV_WIDTH+1:0] count_reg;
   logic [DIV_WIDTH+1:0] terminal;

   // Refuse widths the counter cannot serve
   if (DIV_WIDTH < 1 || DIV_WIDTH > 30) begin : g_bad_width
      $error("timer_tick_gen: DIV_WIDTH out of range");
   end

   // Period minus one: 2*div for odd divisor, 2*div+1 for even
   assign terminal = {1'b0, divValue, evenDivisor};

   // Count carrier enables and pulse at terminal count
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         count_reg <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (carrierEn) begin
            if (count_reg >= terminal) begin
               count_reg <= '0;
               tick <= 1'b1;
            end else begin
               count_reg <= count_reg + 1'b1;
            end
         end
      end
   end

endmodule : timer_tick_gen

/* verilog/demod_framing_config_bank.sv */
// Configuration register bank for demodulator, PLL, framing and host
// UART speed settings, reached over APB.
// Assumes one clock, synchronous active-low reset, carrier-rate enable
// and signal-strength inputs from logic on the same clock.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module demod_framing_config_bank
   import demod_cfg_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic carrierEn,
   input wire logic iStronger,
   input wire logic commActive,
   input wire logic rxBitValid,
   input wire logic rxBit,
   input wire logic rxParityPos,
   output demod_cfg_pkg::cfg_out_s cfgOut,
   output logic useQChannel,
   output logic timerTick,
   output logic rxDataValid,
   output logic rxDataBit,
   output logic rxParityValid,
   output logic rxParityBit
);
   import demod_cfg_pkg::*;

   logic [7:0] demod_reg;
   logic [7:0] txTiming_reg;
   logic [7:0] rxFraming_reg;
   logic [7:0] uartSpeed_reg;
   logic [TIMER_DIV_WIDTH-1:0] timerDiv_reg;
   logic frozenQ_reg;
   logic [7:0] wordIdx;
   logic aligned;
   logic wrEn;
   logic accessPhase;
   logic ackPhase;
   logic mapped;
   logic [31:0] rdNext;
   logic tickRaw;
   logic lockBit;
   logic [1:0] combine;
   logic stickyTick_reg;

   // Upper address bits above the word index must exist
   if (ADDR_WIDTH < 11 || ADDR_WIDTH > 32) begin : g_bad_width
      $error("demod_framing_config_bank: ADDR_WIDTH out of range");
   end

   // Address decode: word index is byte address over four
   assign wordIdx = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'h0)
      && (paddr[ADDR_WIDTH-1:10] == '0);
   assign accessPhase = psel && penable && !pready;
   // Writes land at the edge where the master sees pready high
   assign ackPhase = psel && penable && pready;
   assign wrEn = ackPhase && pwrite && pstrb[0] && mapped;

   // Which indices exist in this bank
   always_comb begin
      mapped = 1'b0;
      if (aligned) begin
         unique case (wordIdx)
            IDX_DEMOD, IDX_RSVD_A, IDX_RSVD_B, IDX_TX_TIMING,
            IDX_RX_FRAMING, IDX_RSVD_C, IDX_UART_SPEED,
            IDX_TIMER_DIV, IDX_STATUS: begin
               mapped = 1'b1;
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
      end
   end

   // Demodulator settings register, all bits writable
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         demod_reg <= RST_DEMOD;
      end else if (wrEn && wordIdx == IDX_DEMOD) begin
         demod_reg <= (pwdata[7:0] & WMASK_DEMOD)
            | (RST_DEMOD & ~WMASK_DEMOD);
      end
   end

   // Transmit timing: only the extra response field is writable
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         txTiming_reg <= RST_TX_TIMING;
      end else if (wrEn && wordIdx == IDX_TX_TIMING) begin
         txTiming_reg <= (pwdata[7:0] & WMASK_TX_TIMING)
            | (RST_TX_TIMING & ~WMASK_TX_TIMING);
      end
   end

   // Receive framing: only the parity bypass bit is writable
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rxFraming_reg <= RST_RX_FRAMING;
      end else if (wrEn && wordIdx == IDX_RX_FRAMING) begin
         rxFraming_reg <= (pwdata[7:0] & WMASK_RX_FRAMING)
            | (RST_RX_FRAMING & ~WMASK_RX_FRAMING);
      end
   end

   // Host UART speed factors
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         uartSpeed_reg <= RST_UART_SPEED;
      end else if (wrEn && wordIdx == IDX_UART_SPEED) begin
         uartSpeed_reg <= pwdata[7:0] & WMASK_UART_SPEED;
      end
   end

   // Timer divider value, byte lanes 0 and 1
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         timerDiv_reg <= RST_TIMER_DIV;
      end else if (ackPhase && pwrite && mapped
            && wordIdx == IDX_TIMER_DIV) begin
         if (pstrb[0]) begin
            timerDiv_reg[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            timerDiv_reg[TIMER_DIV_WIDTH-1:8] <=
               pwdata[TIMER_DIV_WIDTH-1:8];
         end
      end
   end

   // Channel fields of the demodulator settings
   assign lockBit = demod_reg[POS_LOCK];
   assign combine = demod_reg[POS_COMBINE +: 2];

   // Freeze the stronger channel at the start of communication
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         frozenQ_reg <= 1'b0;
      end else if (!commActive) begin
         frozenQ_reg <= !iStronger;
      end
   end

   // Resolve the channel used for reception
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         useQChannel <= 1'b0;
      end else if (lockBit) begin
         useQChannel <= combine[0];
      end else if (combine == 2'h1) begin
         useQChannel <= commActive ? frozenQ_reg : !iStronger;
      end else begin
         useQChannel <= !iStronger;
      end
   end

   // Settings for consumers
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cfgOut <= '0;
      end else begin
         if (lockBit) begin
            cfgOut.channelMode <= combine[0] ? CH_FIXED_Q : CH_FIXED_I;
            cfgOut.channelReserved <= 1'b0;
         end else begin
            cfgOut.channelMode <= combine[0] ? CH_STRONGER_FROZEN
               : CH_STRONGER;
            cfgOut.channelReserved <= combine[1];
         end
         cfgOut.pllTauReception <= demod_reg[POS_TAU_RCV +: 2];
         cfgOut.pllFreezeReception <=
            (demod_reg[POS_TAU_RCV +: 2] == 2'h0);
         cfgOut.pllTauBurst <= demod_reg[POS_TAU_BURST +: 2];
         cfgOut.responseBits <= RESPONSE_BASE_BITS
            + {2'h0, txTiming_reg[1:0]};
         cfgOut.parityBypass <= rxFraming_reg[POS_PARITY_BYPASS];
         cfgOut.baudCoarseFactor <= uartSpeed_reg[POS_COARSE +: 3];
         cfgOut.baudFineFactor <= uartSpeed_reg[POS_FINE +: 5];
      end
   end

   // Timer tick divider
   timer_tick_gen #(
      .DIV_WIDTH(TIMER_DIV_WIDTH)
   ) u_tick (
      .core_clk(core_clk),
      .resetn(resetn),
      .carrierEn(carrierEn),
      .evenDivisor(demod_reg[POS_EVEN]),
      .divValue(timerDiv_reg),
      .tick(tickRaw)
   );

   // Register the tick so the output leaves a flip-flop
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         timerTick <= 1'b0;
      end else begin
         timerTick <= tickRaw;
      end
   end

   // Sticky tick seen flag, cleared by a status read; set wins
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         stickyTick_reg <= 1'b0;
      end else if (tickRaw) begin
         stickyTick_reg <= 1'b1;
      end else if (accessPhase && !pwrite && mapped
            && wordIdx == IDX_STATUS) begin
         stickyTick_reg <= 1'b0;
      end
   end

   // Receive bit path: parity position handled by bypass
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rxDataValid <= 1'b0;
         rxDataBit <= 1'b0;
         rxParityValid <= 1'b0;
         rxParityBit <= 1'b0;
      end else begin
         rxDataBit <= rxBit;
         rxParityBit <= rxBit;
         if (rxFraming_reg[POS_PARITY_BYPASS]) begin
            rxDataValid <= rxBitValid;
            rxParityValid <= 1'b0;
         end else begin
            rxDataValid <= rxBitValid && !rxParityPos;
            rxParityValid <= rxBitValid && rxParityPos;
         end
      end
   end

   // Read data mux
   always_comb begin
      rdNext = 32'h0000_0000;
      if (aligned) begin
         unique case (wordIdx)
            IDX_DEMOD: rdNext = {24'h00_0000, demod_reg};
            IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C: begin
               rdNext = {24'h00_0000, RST_RSVD};
            end
            IDX_TX_TIMING: rdNext = {24'h00_0000, txTiming_reg};
            IDX_RX_FRAMING: rdNext = {24'h00_0000, rxFraming_reg};
            IDX_UART_SPEED: rdNext = {24'h00_0000, uartSpeed_reg};
            IDX_TIMER_DIV: begin
               rdNext = {20'h0_0000, timerDiv_reg};
            end
            IDX_STATUS: begin
               rdNext = {29'h0000_0000, stickyTick_reg, commActive,
                  useQChannel};
            end
            default: rdNext = 32'h0000_0000;
         endcase
      end
   end

   // APB answer: one wait state, ready in the second access cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (accessPhase) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= (!pwrite && mapped) ? rdNext : 32'h0000_0000;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

endmodule : demod_framing_config_bank

/* test/demod_cfg_assertions.sv */
// Checker for the demodulator config bank, bound to its top ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module demod_cfg_assertions
   import demod_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic pready,
   input wire logic iStronger,
   input wire logic commActive,
   input wire logic rxBitValid,
   input wire logic rxBit,
   input wire logic rxParityPos,
   input wire logic rxDataValid,
   input wire logic rxDataBit,
   input wire logic rxParityValid,
   input wire logic rxParityBit,
   input wire logic useQChannel,
   input wire demod_cfg_pkg::cfg_out_s cfgOut
);
   // One clock domain, reset disables every check
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Bus answer and channel resolution
   a_ready_pulse:
      assert property (pready |=> !pready) else $error("pready too long");
   a_fixed_i_chan:
      assert property ((cfgOut.channelMode == CH_FIXED_I)[*3] |-> !useQChannel)
      else $error("I lock lost");
   a_fixed_q_chan:
      assert property ((cfgOut.channelMode == CH_FIXED_Q)[*3] |-> useQChannel)
      else $error("Q lock lost");
   a_stronger_follow:
      assert property ((cfgOut.channelMode == CH_STRONGER
         && $stable(iStronger))[*3] |-> useQChannel == !iStronger)
         else $error("not stronger");
   a_frozen_hold:
      assert property ((cfgOut.channelMode == CH_STRONGER_FROZEN && commActive)
         [*3] |-> $stable(useQChannel)) else $error("frozen channel moved");
   // Derived settings stay consistent with their fields
   a_pll_freeze:
      assert property ($past(resetn) |-> cfgOut.pllFreezeReception ==
         (cfgOut.pllTauReception == 2'h0)) else $error("freeze mismatch");
   a_response_base:
      assert property ($past(resetn) |-> cfgOut.responseBits inside
         {[4'h7:4'hA]}) else $error("response time out of range");
   // Parity slot routing
   a_parity_data:
      assert property (rxBitValid && rxParityPos && cfgOut.parityBypass ##1
         cfgOut.parityBypass |-> rxDataValid && !rxParityValid &&
         rxDataBit == $past(rxBit)) else $error("bypassed parity lost");
   a_parity_check:
      assert property (rxBitValid && rxParityPos && !cfgOut.parityBypass ##1
         !cfgOut.parityBypass |-> rxParityValid && !rxDataValid &&
         rxParityBit == $past(rxBit)) else $error("parity not checked");
   // Main scenarios reached
   cover property (cfgOut.channelMode == CH_STRONGER_FROZEN && commActive);
   cover property (rxParityValid);
   cover property (rxDataValid && cfgOut.parityBypass);
endmodule : demod_cfg_assertions

bind demod_framing_config_bank demod_cfg_assertions i_chk (
   .core_clk, .resetn, .pready, .iStronger, .commActive, .rxBitValid,
   .rxBit, .rxParityPos, .rxDataValid, .rxDataBit, .rxParityValid,
   .rxParityBit, .useQChannel, .cfgOut
);

/* test/demod_framing_config_bank_tb.sv */
// Self-checking bench for the config bank, driven over APB.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/1ps
module demod_framing_config_bank_tb;
   import demod_cfg_pkg::*;
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr, carrierEn;
   logic iStronger, commActive, rxBitValid, rxBit, rxParityPos;
   logic useQChannel, timerTick, rxDataValid, rxDataBit;
   logic rxParityValid, rxParityBit;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   cfg_out_s cfgOut;
   int nFail = 0;
   int totalChecks = 0;
   logic [7:0] idxTab [7] = '{IDX_DEMOD, IDX_RSVD_A, IDX_RSVD_B,
      IDX_TX_TIMING, IDX_RX_FRAMING, IDX_RSVD_C, IDX_UART_SPEED};
   logic [7:0] rstTab [7] = '{8'h4D, 8'h00, 8'h00, 8'h62, 8'h00, 8'h00, 8'hEB};
   logic [7:0] ffTab [7] = '{8'hFF, 8'h00, 8'h00, 8'h63, 8'h10, 8'h00, 8'hFF};
   logic [7:0] modeVal [6] = '{8'h00, 8'h20, 8'h60, 8'hA0, 8'hE0, 8'h80};
   channel_mode_e modeExp [6] = '{CH_STRONGER, CH_FIXED_I, CH_FIXED_Q,
      CH_FIXED_I, CH_FIXED_Q, CH_STRONGER};
   logic qExp [6] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};

   demod_framing_config_bank i_dut (.core_clk, .resetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .carrierEn, .iStronger, .commActive, .rxBitValid, .rxBit, .rxParityPos,
      .cfgOut, .useQChannel, .timerTick, .rxDataValid, .rxDataBit,
      .rxParityValid, .rxParityBit);

   // Free-running core clock
   always #5 core_clk = ~core_clk;

   // Verdict and end of run
   task automatic endSim();
      if (nFail == 0 && totalChecks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : endSim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; waits for pready, the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] d, input logic [31:0] exp, input logic eExp);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'h1);
      if (!wr) chk(prdata, exp);
      chk(pslverr, eExp);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // Received bit in, routed result one cycle later
   task automatic rxSend(input logic pos, input logic b,
      input logic [3:0] exp);
      @(posedge core_clk);
      {rxBitValid, rxBit, rxParityPos} <= {1'h1, b, pos};
      @(posedge core_clk);
      rxBitValid <= 1'h0;
      @(posedge core_clk);
      chk({rxDataValid, rxDataBit, rxParityValid, rxParityBit}, exp);
   endtask : rxSend

   // Cycles between two ticks, carrier enable always high
   task automatic tickPer(input logic [31:0] exp);
      int c;
      repeat (20) @(posedge core_clk);
      c = 0;
      while (timerTick !== 1'h1 && c < 100) begin
         @(posedge core_clk);
         c++;
      end
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while (timerTick !== 1'h1 && c < 100);
      chk(c, exp);
   endtask : tickPer

   // Hang guard
   initial begin
      #100us;
      nFail++;
      endSim();
   end

   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rxBitValid, rxBit} = '0;
      {rxParityPos, iStronger, commActive} = '0;
      pstrb = 4'hF;
      carrierEn = 1'h1;
      repeat (16) @(posedge core_clk);
      resetn <= 1'h1;
      for (int i = 0; i < 7; i++) apb(0, idxTab[i], 0, rstTab[i], 0);
      chk({cfgOut.responseBits, cfgOut.baudCoarseFactor,
         cfgOut.baudFineFactor}, {4'h9, 3'h7, 5'h0B});
      chk({cfgOut.pllTauReception, cfgOut.pllFreezeReception,
         cfgOut.pllTauBurst, cfgOut.channelMode, cfgOut.parityBypass},
         {2'h3, 1'h0, 2'h1, CH_STRONGER_FROZEN, 1'h0});
      for (int i = 0; i < 7; i++) begin
         apb(1, idxTab[i], 32'hFFFFFFFF, 0, 0);
         apb(0, idxTab[i], 0, ffTab[i], 0);
      end
      apb(0, 8'h20, 0, 0, 1);
      apb(1, 8'h20, 32'hFF, 0, 1);
      rxSend(1'h1, 1'h1, 4'hD);
      rxSend(1'h0, 1'h0, 4'h8);
      apb(1, IDX_RX_FRAMING, 0, 0, 0);
      rxSend(1'h1, 1'h0, 4'h2);
      rxSend(1'h0, 1'h1, 4'hD);
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 6; i++) begin
            iStronger <= s[0];
            apb(1, IDX_DEMOD, modeVal[i], 0, 0);
            repeat (3) @(posedge core_clk);
            chk({cfgOut.channelMode, cfgOut.channelReserved, useQChannel},
               {modeExp[i], i == 5, (i == 0 || i == 5) ? !s[0] : qExp[i]
               });
         end
      end
      apb(1, IDX_DEMOD, 8'h40, 0, 0);
      iStronger <= 1'h0;
      repeat (3) @(posedge core_clk);
      chk(useQChannel, 1);
      chk({cfgOut.pllTauReception, cfgOut.pllFreezeReception,
         cfgOut.pllTauBurst}, {2'h0, 1'h1, 2'h0});
      commActive <= 1'h1;
      repeat (2) @(posedge core_clk);
      iStronger <= 1'h1;
      repeat (3) @(posedge core_clk);
      chk(useQChannel, 1);
      commActive <= 1'h0;
      repeat (3) @(posedge core_clk);
      chk(useQChannel, 0);
      apb(1, IDX_TIMER_DIV, 2, 0, 0);
      apb(1, IDX_DEMOD, 8'h4D, 0, 0);
      tickPer(5);
      apb(1, IDX_DEMOD, 8'h5D, 0, 0);
      tickPer(6);
      carrierEn <= 1'h0;
      apb(0, IDX_TIMER_DIV, 0, 32'h0000_0002, 0);
      apb(0, IDX_STATUS, 0, 32'h0000_0004, 0);
      apb(0, IDX_STATUS, 0, 32'h0000_0000, 0);
      carrierEn <= 1'h1;
      apb(1, IDX_UART_SPEED, 8'hA5, 0, 0);
      apb(1, IDX_TX_TIMING, 8'h01, 0, 0);
      repeat (2) @(posedge core_clk);
      chk({cfgOut.responseBits, cfgOut.baudCoarseFactor,
         cfgOut.baudFineFactor}, {4'h8, 3'h5, 5'h05});
      pstrb <= 4'hE;
      apb(1, IDX_UART_SPEED, 32'h0000_0000, 0, 0);
      pstrb <= 4'hF;
      apb(0, IDX_UART_SPEED, 0, 32'h0000_00A5, 0);
      endSim();
   end
endmodule : demod_framing_config_bank_tb
